// *** pkg/dsc_pkg.sv ***
// Package for the dispenser start control block: register map, fields, timing
package dsc_pkg;
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned TICK_US       = 1000;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned DEBOUNCE_MAX_MS = 100;
    localparam int unsigned DELAY_MAX_CS  = 999;
    localparam int unsigned CS_TICKS      = 10;

    localparam logic [7:0] ADDR_MODE      = 8'h00;
    localparam logic [7:0] ADDR_IN_POL    = 8'h04;
    localparam logic [7:0] ADDR_OUT_POL   = 8'h08;
    localparam logic [7:0] ADDR_TIMING    = 8'h0c;
    localparam logic [7:0] ADDR_SENSOR    = 8'h10;
    localparam logic [7:0] ADDR_JOB       = 8'h14;
    localparam logic [7:0] ADDR_STATUS    = 8'h18;
    localparam logic [7:0] ADDR_EVENT     = 8'h1c;
    localparam logic [7:0] ADDR_HOST_IO   = 8'h20;

    localparam logic [31:0] MODE_RESET    = 32'h0000_0000;
    localparam logic [15:0] IN_POL_RESET  = 16'h5555;
    localparam logic [7:0]  OUT_POL_RESET = 8'hff;
    localparam logic [1:0]  AXI_OKAY      = 2'h0;
    localparam logic [1:0]  AXI_DECERR    = 2'h3;

    typedef enum logic [2:0] {
        DSC_OFF        = 3'h0,
        DSC_STATIC     = 3'h1,
        DSC_STATIC_C   = 3'h2,
        DSC_DYNAMIC    = 3'h3,
        DSC_DYNAMIC_C  = 3'h4,
        DSC_SENSOR     = 3'h5,
        DSC_SENSOR_C   = 3'h6
    } dsc_mode_e;

    // Per-input polarity: 2 bits per line
    typedef enum logic [1:0] {
        IN_LOW      = 2'h0,
        IN_HIGH     = 2'h1,
        IN_DISABLED = 2'h2,
        IN_HOST     = 2'h3
    } dsc_inpol_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] in_state;
        logic [7:0] out_state;
    } dsc_event_s;
endpackage

// *** design/dsc_top.sv ***
// Dispenser start control: start input conditioning, job sequencing, AXI4-Lite registers
`timescale 1ns/1ns
module dsc_top
    import dsc_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Control pins and photocell
    input  wire logic [7:0]  start_in,
    input  wire logic [7:0]  sensor_level,
    output logic [7:0]       ctrl_out,
    // Print engine
    input  wire logic        engine_waiting,
    input  wire logic        engine_busy,
    input  wire logic        label_done,
    input  wire logic        host_data,
    output logic             print_label,
    output logic             backfeed
);
    // Control registers
    logic [2:0]  mode;
    logic        report_en;
    logic        latch_en;
    logic [15:0] in_pol;
    logic [7:0]  out_pol;
    logic [7:0]  out_host;
    logic [7:0]  in_host;
    logic [6:0]  debounce_ms;
    logic [9:0]  delay_cs;
    logic [7:0]  threshold;
    logic [15:0] label_target;
    logic        order_active;
    logic [15:0] label_count;
    dsc_event_s  evt;
    // Bus strobes read ahead of the bus logic
    logic        wr_job;
    logic        rd_evt;
    logic        w_strb_ok;

    // Pin synchronisers
    logic [7:0] in_s1, in_s2;
    logic [7:0] lvl_s1, lvl_s2;
    always_ff @(posedge mclk) begin
        in_s1  <= start_in;
        in_s2  <= in_s1;
        lvl_s1 <= sensor_level;
        lvl_s2 <= lvl_s1;
    end

    // Millisecond tick
    logic [31:0] tick_cnt;
    wire         tick_ms = (tick_cnt == TICK_CYC - 1);
    always_ff @(posedge mclk) begin
        if (!rst_n || tick_ms) tick_cnt <= '0;
        else                   tick_cnt <= tick_cnt + 32'h1;
    end

    // Per-line active level
    function automatic logic line_active(input logic [1:0] pol, input logic pin,
                                         input logic host);
        unique case (dsc_inpol_e'(pol))
            IN_LOW:      line_active = ~pin;
            IN_HIGH:     line_active = pin;
            IN_DISABLED: line_active = 1'b0;
            IN_HOST:     line_active = host;
        endcase
    endfunction

    logic [7:0] in_act;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            in_act[i] = line_active(in_pol[2*i +: 2], in_s2[i], in_host[i]);
        end
    end

    wire io_mode     = (mode >= DSC_STATIC) && (mode <= DSC_DYNAMIC_C);
    wire sensor_mode = (mode == DSC_SENSOR) || (mode == DSC_SENSOR_C);
    wire dyn_mode    = (mode == DSC_DYNAMIC) || (mode == DSC_DYNAMIC_C);
    wire cont_mode   = (mode == DSC_STATIC_C) || (mode == DSC_DYNAMIC_C)
                       || (mode == DSC_SENSOR_C);
    // Line 0 is the start input; the line is ignored outside I/O modes
    wire raw_start   = io_mode ? in_act[0] : 1'b0;
    wire label_seen  = (lvl_s2 >= threshold);
    // Photocell only drives starts in sensor modes; elsewhere threshold only sets the label_seen status bit
    wire start_src   = sensor_mode ? ~label_seen : raw_start;

    // Debounce: level must hold for the full time before acceptance
    logic       deb_level;
    logic [6:0] deb_cnt;
    wire        deb_diff = (start_src != deb_level);
    wire        deb_done = deb_diff && (deb_cnt >= debounce_ms);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            deb_level <= 1'b0;
            deb_cnt   <= '0;
        end else if (!deb_diff) begin
            deb_cnt   <= '0;
        end else if (deb_done) begin
            deb_level <= start_src;
            deb_cnt   <= '0;
        end else if (tick_ms) begin
            deb_cnt   <= deb_cnt + 7'h1;
        end
    end
    wire accept_rise = deb_done && start_src;
    // Dynamic mode fires on either edge; static and sensor on the active edge
    wire accept_evt  = dyn_mode ? deb_done : accept_rise;

    // Start delay in centiseconds, begun at acceptance
    logic       dly_run;
    logic [9:0] dly_cs;
    logic [3:0] dly_ms;
    wire        dly_fire = dly_run && (dly_cs >= delay_cs);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dly_run <= 1'b0;
            dly_cs  <= '0;
            dly_ms  <= '0;
        end else if (accept_evt && !dly_run) begin
            dly_run <= 1'b1;
            dly_cs  <= '0;
            dly_ms  <= '0;
        end else if (dly_fire) begin
            dly_run <= 1'b0;
        end else if (dly_run && tick_ms) begin
            if (dly_ms == 4'(CS_TICKS - 1)) begin
                dly_ms <= '0;
                dly_cs <= dly_cs + 10'h1;
            end else begin
                dly_ms <= dly_ms + 4'h1;
            end
        end
    end

    // Ready: order open, engine waiting, nothing in flight
    wire ready     = order_active && engine_waiting && !engine_busy && !print_label;
    wire req_now   = dly_fire && ready;
    // Start during printing is stored only with latching on; else dropped
    logic pend;
    wire  store    = dly_fire && !ready && engine_busy && latch_en;
    wire  static_go = (mode == DSC_STATIC || mode == DSC_STATIC_C)
                      && deb_level && ready;
    wire  go       = (mode != DSC_OFF) && (req_now || (pend && ready) || static_go);
    wire  at_count = (label_count + 16'h1 >= label_target);
    logic data_seen;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pend         <= 1'b0;
            print_label  <= 1'b0;
            backfeed     <= 1'b0;
            label_count  <= '0;
            order_active <= 1'b0;
            data_seen    <= 1'b0;
        end else begin
            print_label <= go;
            backfeed    <= label_done && dyn_mode;
            if (store)          pend <= 1'b1;
            else if (go)        pend <= 1'b0;
            if (host_data)      data_seen <= 1'b1;
            if (wr_job) begin
                order_active <= 1'b1;
                label_count  <= '0;
                data_seen    <= 1'b0;
            end else if (go) begin
                label_count <= label_count + 16'h1;
                // Continuous: new data keeps the order alive past the count
                if (at_count && !(cont_mode && (data_seen || host_data))) begin
                    order_active <= 1'b0;
                end else if (at_count) begin
                    label_count <= '0;
                    data_seen   <= 1'b0;
                end
            end
        end
    end

    // Outputs: line 0 is ready, others follow host bits
    logic [7:0] out_act;
    assign out_act = {out_host[7:1], ready};
    always_ff @(posedge mclk) begin
        if (!rst_n) ctrl_out <= '0;
        else        ctrl_out <= (out_act ~^ out_pol);
    end

    // I/O change reporting
    logic [7:0] last_in;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            last_in <= '0;
            evt     <= '0;
        end else begin
            last_in <= in_s2;
            if (report_en && ((in_s2 != last_in) || (ctrl_out != evt.out_state))) begin
                evt <= '{valid: 1'b1, in_state: in_s2, out_state: ctrl_out};
            end else if (rd_evt) begin
                evt.valid <= 1'b0;
            end
        end
    end

    // AXI4-Lite write path
    logic        aw_hold, w_hold;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    wire  wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    wire  wr_map  = (aw_addr <= ADDR_HOST_IO) && (aw_addr[1:0] == 2'h0);
    assign wr_job = wr_fire && (aw_addr == ADDR_JOB) && w_strb_ok;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb_ok <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold    <= 1'b1;
                w_data    <= s_axi_wdata;
                w_strb_ok <= &s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? AXI_OKAY : AXI_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_hold;
    assign s_axi_wready  = !w_hold;

    // Register stores; partial strobes are ignored to keep fields coherent
    wire wr_ok = wr_fire && w_strb_ok;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode <= MODE_RESET[2:0];  report_en <= 1'b0;  latch_en <= 1'b0;
            in_pol <= IN_POL_RESET;   out_pol <= OUT_POL_RESET;
            out_host <= '0;           in_host <= '0;
            debounce_ms <= '0;        delay_cs <= '0;
            threshold <= '0;          label_target <= 16'h1;
        end else if (wr_ok) begin
            unique case (aw_addr)
                ADDR_MODE: begin
                    mode      <= w_data[2:0];
                    report_en <= w_data[4];
                    latch_en  <= w_data[5];
                end
                ADDR_IN_POL:  in_pol  <= w_data[15:0];
                ADDR_OUT_POL: out_pol <= w_data[7:0];
                ADDR_TIMING: begin
                    // Clamp to the legal ranges
                    debounce_ms <= (w_data[6:0] > 7'(DEBOUNCE_MAX_MS))
                                   ? 7'(DEBOUNCE_MAX_MS) : w_data[6:0];
                    delay_cs    <= (w_data[25:16] > 10'(DELAY_MAX_CS))
                                   ? 10'(DELAY_MAX_CS) : w_data[25:16];
                end
                ADDR_SENSOR:  threshold    <= w_data[7:0];
                ADDR_JOB:     label_target <= w_data[15:0];
                ADDR_HOST_IO: begin
                    in_host  <= w_data[7:0];
                    out_host <= w_data[15:8];
                end
                default: ;
            endcase
        end
    end

    // AXI4-Lite read path
    wire  rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_evt = rd_take && (s_axi_araddr == ADDR_EVENT);
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            ADDR_MODE:    rd_mux = {26'h0, latch_en, report_en, 1'b0, mode};
            ADDR_IN_POL:  rd_mux = {16'h0, in_pol};
            ADDR_OUT_POL: rd_mux = {24'h0, out_pol};
            ADDR_TIMING:  rd_mux = {6'h0, delay_cs, 9'h0, debounce_ms};
            ADDR_SENSOR:  rd_mux = {15'h0, label_seen, lvl_s2, threshold};
            ADDR_JOB:     rd_mux = {label_count, label_target};
            ADDR_STATUS:  rd_mux = {28'h0, pend, deb_level, order_active, ready};
            ADDR_EVENT:   rd_mux = {15'h0, evt.valid, evt.out_state, evt.in_state};
            ADDR_HOST_IO: rd_mux = {16'h0, out_host, in_host};
            default: begin
                rd_mux = '0;
                rd_hit = 1'b0;
            end
        endcase
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= AXI_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? AXI_OKAY : AXI_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
endmodule

// *** sim/dsc_engine_model.sv ***
// Print engine model: waits, prints one label per request, then reports completion
`timescale 1ns/1ns
module dsc_engine_model #(
    parameter int unsigned BUSY_CYC = 12
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Engine handshake
    input  wire logic print_label,
    output logic      engine_waiting,
    output logic      engine_busy,
    output logic      label_done
);
    int unsigned left;

    // Waiting only while idle, so a start is honoured only then
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            left           <= 0;
            engine_busy    <= 1'b0;
            engine_waiting <= 1'b1;
            label_done     <= 1'b0;
        end else begin
            label_done <= (left == 1);
            if (print_label) begin
                left           <= BUSY_CYC;
                engine_busy    <= 1'b1;
                engine_waiting <= 1'b0;
            end else if (left != 0) begin
                left           <= left - 1;
                engine_busy    <= (left != 1);
                engine_waiting <= (left == 1);
            end
        end
    end
endmodule

// *** sim/dsc_monitor.sv ***
// Port checker for the dispenser start control block
`timescale 1ns/1ns
module dsc_monitor
    import dsc_pkg::*;
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Register bus
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Engine side
    input wire logic        engine_waiting,
    input wire logic        label_done,
    input wire logic        print_label,
    input wire logic        backfeed
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_print_single: assert property (print_label |=> !print_label)
        else $error("print request longer than one cycle");
    a_print_waiting: assert property (print_label |-> $past(engine_waiting))
        else $error("print request while engine not waiting");
    a_backfeed_done: assert property (backfeed |-> $past(label_done))
        else $error("backfeed without finished label");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_read_decerr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h20
        |=> s_axi_rresp == AXI_DECERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
endmodule

bind dsc_top dsc_monitor mon (.mclk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
    .engine_waiting, .label_done, .print_label, .backfeed);

// *** sim/tb_top.sv ***
// Testbench: register access, start conditioning and label sequencing
`timescale 1ns/1ns
module tb_top
    import dsc_pkg::*;
;
    logic        mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, engine_waiting, engine_busy, label_done, print_label, backfeed;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, start_in, sensor_level, ctrl_out;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        host_data;
    int          n_mismatch, n_compared, n_print, n_back, cyc;

    // Short tick keeps millisecond timing within a brief run
    dsc_top #(.TICK_CYC(10)) dut (
        .mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .start_in, .sensor_level, .ctrl_out,
        .engine_waiting, .engine_busy, .label_done, .host_data, .print_label, .backfeed
    );
    dsc_engine_model eng (.mclk, .rst_n, .print_label, .engine_waiting, .engine_busy,
        .label_done);

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (print_label === 1'b1) n_print++;
        if (backfeed === 1'b1) n_back++;
    end

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic bus_tmo(input int n);
        if (n >= 200) begin
            n_mismatch++;
            $display("[FAIL] bus answer expected within 200 seen none");
            test_done();
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok) && n < 200);
        do begin
            @(posedge mclk);
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        s_axi_bready <= 1'b0;
        bus_tmo(n);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 200);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        bus_tmo(n);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        axi_rd(a, rd, rr);
        chk(what, exp, rd);
    endtask

    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, start_in} = '0;
        host_data = 1'b0;
        sensor_level = 8'h80;
        {n_mismatch, n_compared, n_print, n_back} = '0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(ADDR_MODE, MODE_RESET, "mode reset");
        rd_chk(ADDR_IN_POL, {16'h0, IN_POL_RESET}, "in_pol reset");
        rd_chk(ADDR_OUT_POL, {24'h0, OUT_POL_RESET}, "out_pol reset");
        axi_rd(8'h40, rd, rr);
        chk("unmapped resp", {30'h0, AXI_DECERR}, {30'h0, rr});
        chk("unmapped data", 32'h0, rd);
        axi_wr(ADDR_SENSOR, 32'h40);
        repeat (8) @(posedge mclk);
        rd_chk(ADDR_SENSOR, 32'h0001_8040, "sensor report");
        // Static: label count bounds the run while the line stays active
        axi_wr(ADDR_TIMING, 32'h2);
        axi_wr(ADDR_MODE, {29'h0, DSC_STATIC});
        axi_wr(ADDR_JOB, 32'h3);
        start_in <= 8'h01;
        repeat (600) @(posedge mclk);
        chk("static labels", 32'd3, 32'(n_print));
        rd_chk(ADDR_JOB, 32'h0003_0003, "static count");
        start_in <= 8'h00;
        // Let the falling level settle before the mode changes
        repeat (100) @(posedge mclk);
        axi_wr(ADDR_TIMING, 32'h0001_0002);
        axi_wr(ADDR_MODE, {29'h0, DSC_DYNAMIC});
        axi_wr(ADDR_JOB, 32'h2);
        start_in <= 8'h01;
        repeat (5) @(posedge mclk);
        chk("ready output", 32'h01, {24'h0, ctrl_out});
        start_in <= 8'h00;
        repeat (200) @(posedge mclk);
        chk("glitch ignored", 32'd3, 32'(n_print));
        start_in <= 8'h01;
        wait_print: begin
            cyc = 0;
            do begin
                @(posedge mclk);
                cyc++;
            end while (print_label !== 1'b1 && cyc < 1000);
        end
        chk_rng("start delay", 100, 140, cyc);
        repeat (100) @(posedge mclk);
        start_in <= 8'h00;
        repeat (300) @(posedge mclk);
        chk("dynamic labels", 32'd5, 32'(n_print));
        chk("backfeeds", 32'd2, 32'(n_back));
        // Taking the present label away starts the next one
        axi_wr(ADDR_MODE, {29'h0, DSC_SENSOR});
        axi_wr(ADDR_JOB, 32'h1);
        sensor_level <= 8'h10;
        repeat (400) @(posedge mclk);
        chk("sensor label", 32'd6, 32'(n_print));
        // Label back on the ledge; let the start level fall before leaving sensor mode
        sensor_level <= 8'h80;
        repeat (100) @(posedge mclk);
        // Continuous: fresh host data carries the order one batch past its count
        axi_wr(ADDR_MODE, {29'h0, DSC_STATIC_C});
        axi_wr(ADDR_JOB, 32'h1);
        host_data <= 1'b1;
        @(posedge mclk);
        host_data <= 1'b0;
        start_in <= 8'h01;
        repeat (300) @(posedge mclk);
        chk("continuous labels", 32'd8, 32'(n_print));
        rd_chk(ADDR_JOB, 32'h0001_0001, "continuous count");
        test_done();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        test_done();
    end
endmodule
